// ### dcc_pkg.sv
package dcc_pkg;
  // APB word offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_NEXT   = 8'h04;
  localparam logic [7:0] A_CMD    = 8'h08;
  localparam logic [7:0] A_POS    = 8'h0C;
  localparam logic [7:0] A_XFER   = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_DSTAT  = 8'h18;
  // Option byte bit positions; bits 3, 1, 0 change meaning by command
  localparam int OPT_WAIT = 7;
  localparam int OPT_SE   = 6;
  localparam int OPT_STOP_ON_RESULT_BLOCK = 5;
  localparam int OPT_FW   = 4;
  localparam int OPT_B3   = 3;
  localparam int OPT_DM   = 2;
  localparam int OPT_B1   = 1;
  localparam int OPT_B0   = 0;
  // Command codes
  localparam logic [7:0] CMD_LOADBUF = 8'h01;
  localparam logic [7:0] CMD_DUMPBUF = 8'h02;
  localparam logic [7:0] CMD_RESTORE = 8'h08;
  localparam logic [7:0] CMD_RPS     = 8'h0A;
  localparam logic [7:0] CMD_READ    = 8'h0C;
  localparam logic [7:0] CMD_WRITE   = 8'h0D;
  localparam logic [7:0] CMD_SEEK    = 8'h0E;
  localparam logic [7:0] CMD_VERIFY  = 8'h0F;
  localparam logic [7:0] CMD_CHAN    = 8'h10;
  // Default data marks
  localparam logic [7:0] MARK_HARD   = 8'hF8;
  localparam logic [7:0] MARK_ESDI   = 8'hFE;
  localparam logic [7:0] MARK_FLOPPY = 8'hFB;
  localparam logic [1:0] MODE_HARD   = 2'h0;
  localparam logic [1:0] MODE_ESDI   = 2'h1;
  localparam logic [1:0] MODE_FLOPPY = 2'h2;
  localparam logic [1:0] OVF_STOP    = 2'h0;
  localparam logic [1:0] OVF_HEAD    = 2'h1;
  localparam logic [1:0] OVF_TRACK   = 2'h2;
  localparam logic [2:0] PARK_STEPS  = 3'h5;
  localparam logic [31:0] NULL_PTR   = 32'h0000_0000;
  // Post-write delay
  localparam int DELAY_NS  = 1000000;
  localparam int CLK_NS    = 10;
  localparam int DELAY_CYC = DELAY_NS / CLK_NS;
  // Result block codes
  localparam logic [3:0] RB_NONE  = 4'h0;
  localparam logic [3:0] RB_SEEK  = 4'h1;
  localparam logic [3:0] RB_FATAL = 4'h2;
  localparam logic [3:0] RB_FLAG  = 4'h3;
  typedef enum logic [2:0] {
    FT_NONE = 3'h0, FT_NORMAL = 3'h1, FT_WAIT = 3'h2, FT_SRB = 3'h3, FT_SE = 3'h4
  } dcc_fault_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_LATCH = 4'h1, S_VERIFY = 4'h3, S_XFER = 4'h2,
    S_FINISH = 4'h6, S_NEXT = 4'h7, S_HALT = 4'h5, S_RESTORE = 4'h4,
    S_DELAY = 4'hC, S_DRV = 4'hD, S_BUF = 4'h8
  } dcc_state_t;
endpackage : dcc_pkg

// ### dcc_chain.sv
// Contract
// - Stop-on-fatal halts the chain after a fatal block; that halt is not resumable.
// - Stop-on-result-block halts right after any result block, resumable only if non-fatal.
// - Map enable makes the data pointer a first map entry, else linear.
// - Without custom mark use mode default mark: hard, enhanced or floppy.
// - With custom mark use the block's mark field, only for read, write, verify and RPS commands.
// - Position check on seek/restore: mismatch gives seek error, no retry.
// - Read/write/verify check track, restore and reseek once, then fatal seek error.
// - Buffer swap toggles sector buffer after a full load or dump.
// - Relocation check runs only when auto relocate on and disable clear.
// - Post-write delay of 1 ms after last track sector before any seek.
// - Restore with park recover steps inward 5 tracks first.
// - Drive command waits for command complete when asked, else proceeds.
// - Drive command with status return waits for and stores drive status.
// - Wait option halts after the block with wait-stop fault, resumable.
// - Stop-on-result-block halts with result-block fault when blocks were written.
// - Stop-on-fatal alone halts only after fatal error with stop-on-error fault.
// - Zero next pointer ends chain with normal completion fault.
// - With no stop options the chain continues regardless of errors.
// - Transfer record count sectors, overflow stops or bumps head or track.
// - Enhanced format compares flag byte with header flag, mismatch gives result block.
// - Read moves disk to memory, write memory to disk.
// - Long access bit selects normal or long transfer with check bytes.
// - Wait halt is resumable and look-ahead stops at a wait block.
//
// Implementation choices: register access over APB and the address map.
module dcc_chain
  import dcc_pkg::*;
#(
  parameter int DELAY_CYCLES = DELAY_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pos_ok,
  input  wire logic        pos_bad,
  input  wire logic [7:0]  id_flag,
  input  wire logic        restore_done,
  input  wire logic        sector_done,
  input  wire logic        buffer_done,
  input  wire logic        cmd_complete,
  input  wire logic        status_valid,
  input  wire logic [15:0] status_data,
  output logic             seek_req,
  output logic             restore_req,
  output logic [2:0]       park_steps,
  output logic             xfer_req,
  output logic             xfer_to_mem,
  output logic             long_access,
  output logic             map_mode,
  output logic             relocate_check,
  output logic [7:0]       data_mark,
  output logic             buf_sel,
  output logic             drive_cmd,
  output logic             result_valid,
  output logic [3:0]       result_code,
  output logic             fault,
  output dcc_fault_t       fault_type,
  output logic             chain_req,
  output logic             lookahead_ok,
  output logic [15:0]      cur_track,
  output logic [7:0]       cur_head,
  output logic [7:0]       cur_sector
);

  function automatic logic is_rwv(input logic [7:0] c);
    is_rwv = (c == CMD_READ) || (c == CMD_WRITE) || (c == CMD_VERIFY);
  endfunction : is_rwv

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [31:0] ctrl_r, next_r, cmd_r, pos_r, xfer_r;
  logic [15:0] drv_status;
  logic        wr_en, go, resume, hit;
  dcc_state_t  state, next_state;
  logic        resumable, srb_seen, fatal_seen, retried, got_status;
  logic [7:0]  opt, cmd, flag;
  logic [31:0] next_ptr;
  logic [7:0]  cnt;
  logic [16:0] dly;
  logic        emit, efatal, halt_res;
  logic [3:0]  ecode;
  dcc_fault_t  halt_ft;
  logic [1:0]  mode, ovf;
  logic [7:0]  spt_last;
  logic        sec_wrap, fw_hit;

  assign mode     = ctrl_r[3:2];
  assign ovf      = ctrl_r[6:5];
  assign spt_last = ctrl_r[15:8];
  assign hit      = (paddr == A_CTRL) || (paddr == A_NEXT) || (paddr == A_CMD) ||
                    (paddr == A_POS) || (paddr == A_XFER) || (paddr == A_STATUS) ||
                    (paddr == A_DSTAT);
  assign wr_en    = psel && penable && pwrite && pready;
  assign go       = wr_en && (paddr == A_CTRL) && pwdata[0];
  assign resume   = wr_en && (paddr == A_CTRL) && pwdata[1];
  assign pslverr  = psel && penable && pready && !hit;

  // One wait state gives the read mux a full cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // Writable registers; start and resume bits are not stored
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 32'h0000_0000;
      next_r <= 32'h0000_0000;
      cmd_r  <= 32'h0000_0000;
      pos_r  <= 32'h0000_0000;
      xfer_r <= 32'h0000_0000;
    end else if (wr_en) begin
      if (paddr == A_CTRL) begin
        ctrl_r <= {pwdata[31:2], 2'h0};
      end else if (paddr == A_NEXT) begin
        next_r <= pwdata;
      end else if (paddr == A_CMD) begin
        cmd_r <= pwdata;
      end else if (paddr == A_POS) begin
        pos_r <= pwdata;
      end else if (paddr == A_XFER) begin
        xfer_r <= pwdata;
      end
    end
  end

  // Read data registered during the wait state
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pwrite && !pready) begin
      if (paddr == A_CTRL) begin
        prdata <= ctrl_r;
      end else if (paddr == A_NEXT) begin
        prdata <= next_r;
      end else if (paddr == A_CMD) begin
        prdata <= cmd_r;
      end else if (paddr == A_POS) begin
        prdata <= {cur_sector, cur_head, cur_track};
      end else if (paddr == A_XFER) begin
        prdata <= xfer_r;
      end else if (paddr == A_STATUS) begin
        prdata <= {18'h0, fatal_seen, srb_seen, result_code, fault_type,
                   buf_sel, chain_req, (state != S_IDLE), resumable, fault};
      end else if (paddr == A_DSTAT) begin
        prdata <= {16'h0, drv_status};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chain sequencer
  assign sec_wrap = (cur_sector == spt_last);
  assign fw_hit   = sec_wrap && (cmd == CMD_WRITE) && opt[OPT_FW];

  always_comb begin
    next_state = state;
    emit       = 1'b0;
    efatal     = 1'b0;
    ecode      = RB_NONE;
    halt_ft    = FT_NONE;
    halt_res   = 1'b0;
    case (state)
      S_IDLE, S_NEXT: begin
        if (go) next_state = S_LATCH;
      end
      S_HALT: begin
        if (go) begin
          next_state = S_LATCH;
        end else if (resume && resumable) begin
          next_state = S_NEXT;
        end
      end
      S_LATCH: begin
        if (is_rwv(cmd_r[15:8])) begin
          next_state = S_VERIFY;
        end else if (cmd_r[15:8] == CMD_RESTORE) begin
          next_state = S_RESTORE;
        end else if ((cmd_r[15:8] == CMD_SEEK || cmd_r[15:8] == CMD_RPS) && cmd_r[OPT_B3]) begin
          next_state = S_VERIFY;
        end else if (cmd_r[15:8] == CMD_CHAN) begin
          next_state = S_DRV;
        end else if (cmd_r[15:8] == CMD_LOADBUF || cmd_r[15:8] == CMD_DUMPBUF) begin
          next_state = S_BUF;
        end else begin
          next_state = S_FINISH;
        end
      end
      S_VERIFY: begin
        if (pos_ok) begin
          // Flag compare only on the enhanced track format
          if (mode == MODE_ESDI && is_rwv(cmd) && id_flag != flag) begin
            emit  = 1'b1;
            ecode = RB_FLAG;
          end
          next_state = is_rwv(cmd) ? S_XFER : S_FINISH;
        end else if (pos_bad) begin
          emit = 1'b1;
          if (is_rwv(cmd) && retried) begin
            ecode      = RB_FATAL;
            efatal     = 1'b1;
            next_state = S_FINISH;
          end else if (is_rwv(cmd)) begin
            ecode      = RB_SEEK;
            next_state = S_RESTORE;
          end else begin
            ecode      = RB_SEEK;
            next_state = S_FINISH;
          end
        end
      end
      S_RESTORE: begin
        if (restore_done) begin
          next_state = (cmd == CMD_RESTORE && !opt[OPT_B3]) ? S_FINISH : S_VERIFY;
        end
      end
      S_XFER: begin
        if (cnt == 8'h00) begin
          next_state = S_FINISH;
        end else if (sector_done) begin
          if (fw_hit) begin
            next_state = S_DELAY;
          end else if (cnt == 8'h01 || (sec_wrap && ovf == OVF_STOP)) begin
            next_state = S_FINISH;
          end else if (sec_wrap) begin
            next_state = S_VERIFY;
          end
        end
      end
      S_DELAY: begin
        if (dly == 17'h0) begin
          next_state = (cnt == 8'h00 || ovf == OVF_STOP) ? S_FINISH : S_VERIFY;
        end
      end
      S_DRV: begin
        if ((!opt[OPT_B0] || cmd_complete) && (!opt[OPT_B1] || got_status)) begin
          next_state = S_FINISH;
        end
      end
      S_BUF: begin
        if (buffer_done) next_state = S_FINISH;
      end
      S_FINISH: begin
        // Policy reads only the latched option copy
        next_state = S_HALT;
        if (opt[OPT_WAIT]) begin
          halt_ft  = FT_WAIT;
          halt_res = 1'b1;
        end else if (opt[OPT_STOP_ON_RESULT_BLOCK] && srb_seen) begin
          halt_ft  = FT_SRB;
          halt_res = !fatal_seen;
        end else if (opt[OPT_SE] && fatal_seen) begin
          halt_ft  = FT_SE;
        end else if (next_ptr == NULL_PTR) begin
          halt_ft  = FT_NORMAL;
        end else begin
          next_state = S_NEXT;
        end
      end
      default: next_state = S_IDLE;
    endcase
    // Result-block stop cuts the command short, SE cases included
    if (emit && opt[OPT_STOP_ON_RESULT_BLOCK]) begin
      next_state = S_HALT;
      halt_ft    = FT_SRB;
      halt_res   = !efatal;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) state <= S_IDLE;
    else        state <= next_state;
  end

  // Fault flag and type, set on entry to halt
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fault      <= 1'b0;
      fault_type <= FT_NONE;
      resumable  <= 1'b0;
    end else if (next_state == S_HALT && state != S_HALT) begin
      fault      <= 1'b1;
      fault_type <= halt_ft;
      resumable  <= halt_res;
    end else if (state == S_HALT && next_state != S_HALT) begin
      fault      <= 1'b0;
      fault_type <= FT_NONE;
      resumable  <= 1'b0;
    end
  end

  // Per-block latch of options and command fields
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      opt            <= 8'h00;
      cmd            <= 8'h00;
      flag           <= 8'h00;
      next_ptr       <= 32'h0000_0000;
      data_mark      <= MARK_HARD;
      map_mode       <= 1'b0;
      relocate_check <= 1'b0;
      long_access    <= 1'b0;
      xfer_to_mem    <= 1'b0;
      park_steps     <= 3'h0;
    end else if (state == S_LATCH) begin
      opt      <= cmd_r[7:0];
      cmd      <= cmd_r[15:8];
      flag     <= cmd_r[31:24];
      next_ptr <= next_r;
      if (cmd_r[OPT_DM] && (is_rwv(cmd_r[15:8]) || cmd_r[15:8] == CMD_RPS)) begin
        data_mark <= xfer_r[7:0];
      end else if (mode == MODE_ESDI) begin
        data_mark <= MARK_ESDI;
      end else if (mode == MODE_FLOPPY) begin
        data_mark <= MARK_FLOPPY;
      end else begin
        data_mark <= MARK_HARD;
      end
      map_mode       <= cmd_r[OPT_B3] && cmd_r[15:8] != CMD_SEEK &&
                        cmd_r[15:8] != CMD_RESTORE && cmd_r[15:8] != CMD_RPS;
      relocate_check <= is_rwv(cmd_r[15:8]) && ctrl_r[4] && !cmd_r[OPT_B0];
      long_access    <= xfer_r[24];
      xfer_to_mem    <= (cmd_r[15:8] == CMD_READ);
      park_steps     <= (cmd_r[15:8] == CMD_RESTORE && cmd_r[OPT_B0]) ? PARK_STEPS : 3'h0;
    end
  end

  // Block progress flags; clear at latch beats set
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      srb_seen   <= 1'b0;
      fatal_seen <= 1'b0;
      retried    <= 1'b0;
    end else begin
      if (state == S_LATCH) begin
        srb_seen   <= 1'b0;
        fatal_seen <= 1'b0;
        retried    <= 1'b0;
      end else if (emit) begin
        srb_seen   <= 1'b1;
        fatal_seen <= fatal_seen || efatal;
      end
      if (state == S_VERIFY && pos_bad) begin
        retried <= 1'b1;
      end else if (state == S_XFER && sector_done && sec_wrap) begin
        retried <= 1'b0;  // New track gets its own retry
      end
    end
  end

  // Result block pulse
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      result_valid <= 1'b0;
      result_code  <= RB_NONE;
    end else begin
      result_valid <= emit;
      if (emit) result_code <= ecode;
    end
  end

  // Position and record count walk
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur_track  <= 16'h0000;
      cur_head   <= 8'h00;
      cur_sector <= 8'h00;
      cnt        <= 8'h00;
    end else if (state == S_LATCH) begin
      cur_track  <= pos_r[15:0];
      cur_head   <= pos_r[23:16];
      cur_sector <= pos_r[31:24];
      cnt        <= xfer_r[15:8];
    end else if (state == S_XFER && sector_done && cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      if (!sec_wrap) begin
        cur_sector <= cur_sector + 8'h01;
      end else if (ovf == OVF_HEAD) begin
        cur_sector <= 8'h00;
        cur_head   <= cur_head + 8'h01;
      end else if (ovf == OVF_TRACK) begin
        cur_sector <= 8'h00;
        cur_track  <= cur_track + 16'h0001;
      end
    end
  end

  // Post-write delay counter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dly <= 17'h0;
    end else if (next_state == S_DELAY && state != S_DELAY) begin
      dly <= 17'(DELAY_CYCLES - 1);
    end else if (state == S_DELAY && dly != 17'h0) begin
      dly <= dly - 17'h1;
    end
  end

  // Drive channel: command pulse, status capture, buffer swap
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      drive_cmd  <= 1'b0;
      got_status <= 1'b0;
      drv_status <= 16'h0000;
      buf_sel    <= 1'b0;
    end else begin
      drive_cmd <= (state == S_LATCH) && (next_state == S_DRV);
      if (state == S_LATCH) begin
        got_status <= 1'b0;
      end else if (state == S_DRV && opt[OPT_B1] && status_valid) begin
        got_status <= 1'b1;
        drv_status <= status_data;
      end
      if (state == S_BUF && buffer_done && opt[OPT_B0]) begin
        buf_sel <= !buf_sel;
      end
    end
  end

  assign seek_req     = (state == S_VERIFY);
  assign restore_req  = (state == S_RESTORE);
  assign xfer_req     = (state == S_XFER);
  assign chain_req    = (state == S_NEXT);
  // No look-ahead past a wait block
  assign lookahead_ok = (state != S_IDLE) && (state != S_HALT) && !opt[OPT_WAIT];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_wait;
    state == S_FINISH && opt[OPT_WAIT] |=> state == S_HALT && fault_type == FT_WAIT && resumable;
  endproperty
  a_wait: assert property (p_wait) else $error("wait stop wrong");
  property p_stop_on_result_block;
    emit && opt[OPT_STOP_ON_RESULT_BLOCK] |=> state == S_HALT && fault_type == FT_SRB && result_valid;
  endproperty
  a_stop_on_result_block: assert property (p_stop_on_result_block) else $error("result-block stop wrong");
  property p_se;
    state == S_FINISH && !opt[OPT_WAIT] && !opt[OPT_STOP_ON_RESULT_BLOCK] && opt[OPT_SE] && fatal_seen
      |=> fault_type == FT_SE && !resumable;
  endproperty
  a_se: assert property (p_se) else $error("stop on fatal wrong");
  property p_cont;
    state == S_FINISH && opt[7:5] == 3'h0 && next_ptr != NULL_PTR |=> state == S_NEXT && !fault;
  endproperty
  a_cont: assert property (p_cont) else $error("chain did not continue");
  property p_norm;
    state == S_FINISH && opt[7:5] == 3'h0 && next_ptr == NULL_PTR |=> fault_type == FT_NORMAL;
  endproperty
  a_norm: assert property (p_norm) else $error("normal end wrong");
  property p_retry;
    state == S_VERIFY && pos_bad && is_rwv(cmd) && !retried && !opt[OPT_STOP_ON_RESULT_BLOCK]
      |=> restore_req ##0 result_code == RB_SEEK;
  endproperty
  a_retry: assert property (p_retry) else $error("no restore retry");
  property p_fatal_seek;
    state == S_VERIFY && pos_bad && is_rwv(cmd) && retried |=> result_valid && result_code == RB_FATAL;
  endproperty
  a_fatal_seek: assert property (p_fatal_seek) else $error("no fatal seek");
  property p_tv;
    state == S_VERIFY && pos_bad && !is_rwv(cmd) |=> result_code == RB_SEEK && !restore_req;
  endproperty
  a_tv: assert property (p_tv) else $error("check retried");
  property p_park;
    restore_req |-> park_steps == ((cmd == CMD_RESTORE && opt[OPT_B0]) ? PARK_STEPS : 3'h0);
  endproperty
  a_park: assert property (p_park) else $error("park steps wrong");
  property p_drv;
    state == S_DRV && opt[OPT_B0] && !cmd_complete |=> state == S_DRV;
  endproperty
  a_drv: assert property (p_drv) else $error("left before complete");
  property p_delay;
    state == S_DELAY && next_state != S_DELAY |-> dly == 17'h0;
  endproperty
  a_delay: assert property (p_delay) else $error("delay cut short");

  c_wait_stop: cover property (state == S_FINISH && opt[OPT_WAIT]);
  c_retry_fatal: cover property (result_valid && result_code == RB_FATAL);
  c_delay_done: cover property (state == S_DELAY && dly == 17'h0);
  c_resume: cover property (state == S_HALT && resume && resumable);

endmodule : dcc_chain

// ### dcc_drive_model.sv
module dcc_drive_model
  import dcc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        seek_req,
  input  wire logic        restore_req,
  input  wire logic        xfer_req,
  input  wire logic        drive_cmd,
  input  wire logic [3:0]  lag,
  input  wire logic [1:0]  bad_seeks,
  input  wire logic [7:0]  flag,
  input  wire logic [15:0] stat,
  output logic             pos_ok,
  output logic             pos_bad,
  output logic [7:0]       id_flag,
  output logic             restore_done,
  output logic             sector_done,
  output logic             buffer_done,
  output logic             cmd_complete,
  output logic             status_valid,
  output logic [15:0]      status_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wt;
  logic [1:0] bads;
  logic       cc_d;
  logic       req;
  logic       fire;

  // One answer per request after lag cycles; no answer while a pulse is out
  assign req         = seek_req | restore_req | xfer_req;
  assign fire        = req && wt == lag && !(pos_ok | pos_bad | restore_done | sector_done);
  assign buffer_done = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Drive side; idle data lines toggle so stale values are never trusted
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {wt, bads, cc_d, pos_ok, pos_bad, restore_done, sector_done} <= '0;
      {cmd_complete, status_valid, id_flag, status_data} <= '0;
    end else begin
      wt           <= (req && !fire) ? wt + 4'h1 : 4'h0;
      bads         <= bads + 2'(fire && seek_req && bads < bad_seeks);
      pos_ok       <= fire && seek_req && bads >= bad_seeks;
      pos_bad      <= fire && seek_req && bads < bad_seeks;
      restore_done <= fire && restore_req;
      sector_done  <= fire && xfer_req;
      id_flag      <= fire ? flag : ~id_flag;
      cc_d         <= drive_cmd;
      cmd_complete <= !drive_cmd && (cmd_complete || cc_d);
      status_valid <= cc_d;
      status_data  <= cc_d ? stat : ~status_data;
    end
  end
endmodule : dcc_drive_model

// ### dcc_chain_tb.sv
module dcc_chain_tb
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0]  paddr = 8'h00, id_flag, data_mark, cur_head, cur_sector;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, pos_ok, pos_bad, restore_done, sector_done, buffer_done;
  logic        cmd_complete, status_valid, seek_req, restore_req, xfer_req, xfer_to_mem;
  logic        long_access, map_mode, relocate_check, buf_sel, drive_cmd, result_valid;
  logic        fault, chain_req, lookahead_ok;
  logic [15:0] status_data, cur_track;
  logic [3:0]  result_code, lag = 4'h0;
  logic [2:0]  park_steps;
  logic [1:0]  bads = 2'h0;
  dcc_fault_t  fault_type;
  int          fails = 0, total_checks = 0;

  always #5 clock = ~clock;

  dcc_chain #(.DELAY_CYCLES(20)) i_dcc_chain (.clock, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pos_ok, .pos_bad, .id_flag, .restore_done,
    .sector_done, .buffer_done, .cmd_complete, .status_valid, .status_data, .seek_req,
    .restore_req, .park_steps, .xfer_req, .xfer_to_mem, .long_access, .map_mode,
    .relocate_check, .data_mark, .buf_sel, .drive_cmd, .result_valid, .result_code, .fault,
    .fault_type, .chain_req, .lookahead_ok, .cur_track, .cur_head, .cur_sector);

  dcc_drive_model i_dcc_drive_model (.clock, .rst_b, .seek_req, .restore_req, .xfer_req,
    .drive_cmd, .lag, .bad_seeks(bads), .flag(8'h3C), .stat(16'hA5C3), .pos_ok, .pos_bad,
    .id_flag, .restore_done, .sector_done, .buffer_done, .cmd_complete, .status_valid,
    .status_data);

  //////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // APB cycle; one idle edge after it so psel never moves twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock);
    end
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clock);
    chk("pready", n < 20, 1'b1);
  endtask : apb

  // Fresh reset, load one block, start, spoil the command reg, await stop or next request
  task run(input logic [3:0] lg, input logic [1:0] bs, input logic [31:0] ctl, cmd, xf, nx,
           input logic stp);
    int n;
    n = 0;
    {lag, bads, rst_b} <= {lg, bs, 1'b0};
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    apb(1'b1, A_NEXT, nx);
    apb(1'b1, A_CMD, cmd);
    apb(1'b1, A_XFER, xf);
    apb(1'b1, A_CTRL, ctl | 32'h1);
    apb(1'b1, A_CMD, 32'h0);
    while (fault !== 1'b1 && chain_req !== 1'b1 && n < 400) begin
      n++;
      @(posedge clock);
    end
    apb(1'b0, A_STATUS, 32'h0);
    chk("fault", fault, stp);
    chk("chain_req", chain_req, !stp);
  endtask : run

  task t_wait;
    run(4'h6, 2'h0, 32'h0F08, 32'h3C000C80, 32'h0100, 32'h0100, 1'b1);
    chk("ftype", fault_type, FT_WAIT);
    chk("resumable", q[1], 1'b1);
    chk("to_mem", xfer_to_mem, 1'b1);
    chk("mark", data_mark, MARK_FLOPPY);
    apb(1'b1, A_CTRL, 32'h2);
    chk("resume", chain_req, 1'b1);
    chk("lookahead", lookahead_ok, 1'b0);
  endtask : t_wait

  task t_fatal;
    run(4'h0, 2'h2, 32'h0F00, 32'h3C000C4C, 32'h015A, 32'h0100, 1'b1);
    chk("ftype", fault_type, FT_SE);
    chk("code", q[11:8], RB_FATAL);
    chk("resumable", q[1], 1'b0);
    chk("mark", data_mark, 8'h5A);
    chk("map", map_mode, 1'b1);
  endtask : t_fatal

  // Two-sector write across two head wraps, each followed by the post-write delay
  task t_normal;
    run(4'h3, 2'h1, 32'h0034, 32'h3C000D10, 32'h01000200, 32'h0, 1'b1);
    chk("ftype", fault_type, FT_NORMAL);
    chk("srb_seen", q[12], 1'b1);
    chk("code", q[11:8], RB_SEEK);
    chk("to_mem", xfer_to_mem, 1'b0);
    chk("mark", data_mark, MARK_ESDI);
    chk("reloc", relocate_check, 1'b1);
    chk("long", long_access, 1'b1);
    chk("head", cur_head, 8'h02);
  endtask : t_normal

  task t_srb;
    run(4'h2, 2'h1, 32'h0F00, 32'h3C000C20, 32'h0100, 32'h0100, 1'b1);
    chk("ftype", fault_type, FT_SRB);
    chk("resumable", q[1], 1'b1);
  endtask : t_srb

  // Restore with park recovery, then an unmapped read
  task t_park;
    run(4'h4, 2'h0, 32'h0F00, 32'h3C000801, 32'h0, 32'h0, 1'b1);
    chk("park", park_steps, PARK_STEPS);
    chk("ftype", fault_type, FT_NORMAL);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", err, 1'b1);
    chk("rdata", q, 32'h0);
  endtask : t_park

  // Fatal block with no stop option runs on; a drive command with status ends the chain
  task t_cont;
    run(4'h0, 2'h2, 32'h0F00, 32'h3C000C00, 32'h0100, 32'h0100, 1'b0);
    chk("fatal", q[13], 1'b1);
    chk("lookahead", lookahead_ok, 1'b1);
    apb(1'b1, A_CMD, 32'h3C001003);
    apb(1'b1, A_NEXT, 32'h0);
    apb(1'b1, A_CTRL, 32'h0F01);
    repeat (8) @(posedge clock);
    apb(1'b0, A_DSTAT, 32'h0);
    chk("dstat", q[15:0], 16'hA5C3);
    chk("ftype", fault_type, FT_NORMAL);
  endtask : t_cont

  task end_sim;
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    t_wait;
    t_fatal;
    t_normal;
    t_srb;
    t_park;
    t_cont;
    end_sim();
  end

  // Watchdog well past the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    end_sim();
  end
endmodule : dcc_chain_tb
